// ### rtl/pps_pkg.sv
/*
  package for the pcie phy status/control block: power states, status codes,
  apb register map, reset values and timing counts.
  assumes a 25 mhz parallel clock.
*/
package pps_pkg;
  localparam logic [1:0] PPS_PWR_P0 = 2'h0;
  localparam logic [1:0] PPS_PWR_P0S = 2'h1;
  localparam logic [1:0] PPS_PWR_P1 = 2'h2;
  localparam logic [1:0] PPS_PWR_P2 = 2'h3;

  localparam logic [2:0] PPS_ST_OK = 3'h0;
  localparam logic [2:0] PPS_ST_SKP_ADD = 3'h1;
  localparam logic [2:0] PPS_ST_SKP_DEL = 3'h2;
  localparam logic [2:0] PPS_ST_RX_DET = 3'h3;
  localparam logic [2:0] PPS_ST_DEC_ERR = 3'h4;
  localparam logic [2:0] PPS_ST_EB_OVF = 3'h5;
  localparam logic [2:0] PPS_ST_EB_UNF = 3'h6;
  localparam logic [2:0] PPS_ST_DISP_ERR = 3'h7;

  localparam logic [11:0] PPS_OFS_CTRL = 12'h000;
  localparam logic [11:0] PPS_OFS_STAT = 12'h004;
  localparam logic [11:0] PPS_OFS_IRQ = 12'h008;
  localparam logic [11:0] PPS_OFS_MASK = 12'h00C;

  localparam int PPS_CTRL_EI_INFER = 0;
  localparam int PPS_CTRL_RX_FAR = 1;
  localparam int PPS_IRQ_DONE = 0;
  localparam int PPS_IRQ_RXDET = 1;
  localparam int PPS_IRQ_ERR = 2;
  localparam int PPS_IRQ_W = 3;

  localparam logic [31:0] PPS_CTRL_RST = 32'h0000_0003;
  localparam logic [2:0] PPS_MASK_RST = 3'h0;

  localparam int PPS_CLK_MHZ = 25;
  localparam int PPS_PWR_CHG_NS = 160;
  localparam int PPS_PWR_CHG_CYC = (PPS_PWR_CHG_NS * PPS_CLK_MHZ + 999) / 1000;
  localparam int PPS_RXDET_NS = 400;
  localparam int PPS_RXDET_CYC = (PPS_RXDET_NS * PPS_CLK_MHZ + 999) / 1000;
  localparam int PPS_RATE_NS = 240;
  localparam int PPS_RATE_CYC = (PPS_RATE_NS * PPS_CLK_MHZ + 999) / 1000;
  localparam int PPS_CNT_W = 8;
  localparam logic [1:0] PPS_SYNC_LAT = 2'h3;

  typedef enum logic [1:0] {PPS_OP_PWR, PPS_OP_RXDET, PPS_OP_RATE} pps_op_e;
endpackage

// ### rtl/pps_sync.sv
/*
  two-flop synchroniser for one asynchronous level.
  assumes the input is a plain level from outside the clock domain.
*/
module pps_sync (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_r;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_r <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule

// ### rtl/pps_top.sv
/*
  per-channel pcie phy status and control: detect/loopback requests, receive
  status, done pulse, receive valid, electrical idle, datapath resets and
  power-down, with an apb register file and one interrupt.
  assumes a link-layer controller on the same chip drives the phy inputs,
  which arrive asynchronously, and an apb master on clk_in.
*/
// Chosen here: the APB slave port and the placing of the registers.
// Contract
// - detect request in P1 with idle forced starts receiver detection
// - request in P0 without idle force switches into reverse parallel loopback
// - 3-bit status: 000 ok, 001 skip added, 010 removed, 011 detected
// - status 100 decode, 101 overflow, 110 underflow, 111 disparity error
// - done pulses one cycle after power change, detection or rate switch
// - receive valid marks valid received data and control flags
// - inference enabled: idle indicator follows inferred electrical idle
// - inference disabled: idle indicator is inverse of signal detect
// - block power-down powers down everything except reference clock buffers
// - receive pcs reset holds receiver pcs in reset
// - transmit pcs reset holds transmitter pcs in reset
// - receive pma reset holds receiver pma in reset
// - power select 00 P0, 01 P0s, 10 P1, 11 P2
// - transmit idle force drives electrical idle instead of data
module pps_top
  import pps_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [1:0] power_sel_in,
  input wire logic tx_idle_force_in,
  input wire logic detect_loop_in,
  input wire logic rate_gen2_in,
  input wire logic rx_far_present_in,
  input wire logic rx_sig_detect_in,
  input wire logic ei_inferred_in,
  input wire logic rx_data_ok_in,
  input wire logic [2:0] rx_event_in,
  input wire logic block_powerdown_in,
  input wire logic rx_pcs_reset_in,
  input wire logic tx_pcs_reset_in,
  input wire logic rx_pma_reset_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [2:0] rx_status_out,
  output logic phy_done_out,
  output logic rx_valid_out,
  output logic rx_idle_out,
  output logic tx_elec_idle_out,
  output logic rev_loopback_out,
  output logic rxdet_active_out,
  output logic rx_pcs_hold_out,
  output logic tx_pcs_hold_out,
  output logic rx_pma_hold_out,
  output logic powered_down_out,
  output logic irq_out
);
  localparam int NS = 13;
  logic [NS-1:0] raw;
  logic [NS-1:0] syn;
  logic [1:0] pwr_s;
  logic idle_s, req_s, gen2_s, far_s, sigdet_s, ei_s, dok_s;
  logic [2:0] evt_s;
  logic pd_s, rxpcs_s, txpcs_s, rxpma_s;

  assign raw = {power_sel_in, tx_idle_force_in, detect_loop_in, rate_gen2_in,
                rx_far_present_in, rx_sig_detect_in, ei_inferred_in, rx_data_ok_in,
                rx_event_in, block_powerdown_in};
  assign {pwr_s, idle_s, req_s, gen2_s, far_s, sigdet_s, ei_s, dok_s, evt_s, pd_s} =
    syn[NS-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      pps_sync u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .d_in(raw[gi]),
        .q_out(syn[gi])
      );
    end
  endgenerate

  // the resets are synchronised like the rest; a pulse of the two-cycle
  // minimum width still reaches the holds
  pps_sync u_rxpcs (.clk_in(clk_in), .reset_in(reset_in), .d_in(rx_pcs_reset_in),
                    .q_out(rxpcs_s));
  pps_sync u_txpcs (.clk_in(clk_in), .reset_in(reset_in), .d_in(tx_pcs_reset_in),
                    .q_out(txpcs_s));
  pps_sync u_rxpma (.clk_in(clk_in), .reset_in(reset_in), .d_in(rx_pma_reset_in),
                    .q_out(rxpma_s));

  // registers
  logic [31:0] ctrl_r;
  logic [PPS_IRQ_W-1:0] irq_stat_r, irq_mask_r, evt_set;
  logic ei_infer_en, apb_wr, apb_rd;
  assign ei_infer_en = ctrl_r[PPS_CTRL_EI_INFER];
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite && !penable;

  // phy operation sequencer
  typedef enum {PPS_S_IDLE, PPS_S_BUSY, PPS_S_HOLD} pps_st_e;
  pps_st_e state_r;
  pps_op_e op_r;
  logic [PPS_CNT_W-1:0] cnt_r;
  logic [1:0] pwr_r;
  logic gen2_r, rx_det_hit_r, det_ok;
  logic start_pwr, start_det, start_rate, live;

  assign live = !pd_s;
  assign det_ok = req_s && idle_s && (pwr_s == PPS_PWR_P1);
  assign start_pwr = pwr_s != pwr_r;
  assign start_rate = gen2_s != gen2_r;
  assign start_det = det_ok;

  // synchronisers show their reset value at first; the sequencer only
  // copies the pins until they arrive, so reset never fakes a change
  logic [1:0] warm_r;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      warm_r <= 2'h0;
    end else if (warm_r != PPS_SYNC_LAT) begin
      warm_r <= warm_r + 2'h1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_r <= PPS_S_IDLE;
      op_r <= PPS_OP_PWR;
      cnt_r <= '0;
      pwr_r <= PPS_PWR_P1;
      gen2_r <= 1'b0;
      phy_done_out <= 1'b0;
      rxdet_active_out <= 1'b0;
      rx_det_hit_r <= 1'b0;
    end else begin
      phy_done_out <= 1'b0;
      case (state_r)
        PPS_S_IDLE: begin
          if (warm_r != PPS_SYNC_LAT) begin
            pwr_r <= pwr_s;
            gen2_r <= gen2_s;
          end else if (!live) begin
            state_r <= PPS_S_IDLE;
          end else if (start_pwr) begin
            op_r <= PPS_OP_PWR;
            pwr_r <= pwr_s;
            cnt_r <= PPS_CNT_W'(PPS_PWR_CHG_CYC);
            state_r <= PPS_S_BUSY;
          end else if (start_rate) begin
            op_r <= PPS_OP_RATE;
            gen2_r <= gen2_s;
            cnt_r <= PPS_CNT_W'(PPS_RATE_CYC);
            state_r <= PPS_S_BUSY;
          end else if (start_det) begin
            op_r <= PPS_OP_RXDET;
            rxdet_active_out <= 1'b1;
            cnt_r <= PPS_CNT_W'(PPS_RXDET_CYC);
            state_r <= PPS_S_BUSY;
          end
        end
        PPS_S_BUSY: begin
          if (cnt_r > PPS_CNT_W'(1)) begin
            cnt_r <= cnt_r - PPS_CNT_W'(1);
          end else begin
            phy_done_out <= 1'b1;
            rxdet_active_out <= 1'b0;
            rx_det_hit_r <= (op_r == PPS_OP_RXDET) && far_s;
            state_r <= (op_r == PPS_OP_RXDET) ? PPS_S_HOLD : PPS_S_IDLE;
          end
        end
        PPS_S_HOLD: begin
          // wait for the controller to drop the request so one request
          // cannot retrigger a second detection
          rx_det_hit_r <= 1'b0;
          if (!req_s) begin
            state_r <= PPS_S_IDLE;
          end
        end
        default: state_r <= PPS_S_IDLE;
      endcase
    end
  end

  // datapath controls
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rev_loopback_out <= 1'b0;
      tx_elec_idle_out <= 1'b1;
      powered_down_out <= 1'b1;
      rx_pcs_hold_out <= 1'b1;
      tx_pcs_hold_out <= 1'b1;
      rx_pma_hold_out <= 1'b1;
    end else begin
      rev_loopback_out <= live && req_s && !idle_s && (pwr_s == PPS_PWR_P0);
      tx_elec_idle_out <= idle_s || !live;
      powered_down_out <= pd_s;
      rx_pcs_hold_out <= rxpcs_s || pd_s;
      tx_pcs_hold_out <= txpcs_s || pd_s;
      rx_pma_hold_out <= rxpma_s || pd_s;
    end
  end

  // receive status, valid and idle
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_status_out <= PPS_ST_OK;
      rx_valid_out <= 1'b0;
      rx_idle_out <= 1'b1;
    end else begin
      if (rx_det_hit_r) begin
        rx_status_out <= PPS_ST_RX_DET;
      end else if (rx_pcs_hold_out || !live) begin
        rx_status_out <= PPS_ST_OK;
      end else begin
        rx_status_out <= evt_s;
      end
      rx_valid_out <= dok_s && live && !rx_pcs_hold_out;
      if (!live) begin
        rx_idle_out <= 1'b1;
      end else if (ei_infer_en) begin
        rx_idle_out <= ei_s;
      end else begin
        rx_idle_out <= !sigdet_s;
      end
    end
  end

  // sticky events, set wins over a write-one clear
  assign evt_set[PPS_IRQ_DONE] = phy_done_out;
  assign evt_set[PPS_IRQ_RXDET] = rx_det_hit_r;
  assign evt_set[PPS_IRQ_ERR] = rx_status_out[2];

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_stat_r <= '0;
      irq_mask_r <= PPS_MASK_RST;
      ctrl_r <= PPS_CTRL_RST;
      irq_out <= 1'b0;
    end else begin
      if (apb_wr && paddr == PPS_OFS_IRQ) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[PPS_IRQ_W-1:0]) | evt_set;
      end else begin
        irq_stat_r <= irq_stat_r | evt_set;
      end
      if (apb_wr && paddr == PPS_OFS_MASK) begin
        irq_mask_r <= pwdata[PPS_IRQ_W-1:0];
      end
      if (apb_wr && paddr == PPS_OFS_CTRL) begin
        ctrl_r <= {30'h0000_0000, pwdata[1:0]};
      end
      irq_out <= |(irq_stat_r & irq_mask_r);
    end
  end

  // apb: no wait state, pready high in the first access cycle, read data latched in setup
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == PPS_OFS_CTRL || paddr == PPS_OFS_STAT ||
                                       paddr == PPS_OFS_IRQ || paddr == PPS_OFS_MASK);
      if (apb_rd) begin
        case (paddr)
          PPS_OFS_CTRL: prdata <= ctrl_r;
          PPS_OFS_STAT: prdata <= {16'h0000, 3'h0, rx_status_out, 1'b0, rx_idle_out,
                                   rx_valid_out, rxdet_active_out, rev_loopback_out,
                                   powered_down_out, gen2_r, 1'b0, pwr_r};
          PPS_OFS_IRQ: prdata <= {29'h0000_0000, irq_stat_r};
          PPS_OFS_MASK: prdata <= {29'h0000_0000, irq_mask_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ### verif/pps_chk_sva.sv
/* assertions on the pps_top ports.
   assumes one clock domain; inputs show 3 edges after a change. */
module pps_chk
  import pps_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic detect_loop_in,
  input wire logic tx_idle_force_in,
  input wire logic block_powerdown_in,
  input wire logic rx_pcs_reset_in,
  input wire logic tx_pcs_reset_in,
  input wire logic rx_pma_reset_in,
  input wire logic [2:0] rx_status_out,
  input wire logic phy_done_out,
  input wire logic tx_elec_idle_out,
  input wire logic rev_loopback_out,
  input wire logic rxdet_active_out,
  input wire logic rx_pcs_hold_out,
  input wire logic tx_pcs_hold_out,
  input wire logic rx_pma_hold_out,
  input wire logic powered_down_out
);
  // synchronisers hold reset values for 3 edges, so $past is not trusted before
  logic [1:0] warm_r;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      warm_r <= 2'h0;
    end else if (warm_r != 2'h3) begin
      warm_r <= warm_r + 2'h1;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in || warm_r != 2'h3);
  sequence s_pulse;
    phy_done_out ##1 !phy_done_out;
  endsequence
  sequence s_det_run;
    rxdet_active_out [*8] ##3 (phy_done_out && !rxdet_active_out);
  endsequence
  a_done_single: assert property (phy_done_out |-> s_pulse)
    else $error("done pulse too long");
  a_det_length: assert property ($rose(rxdet_active_out) |-> s_det_run)
    else $error("detection length wrong");
  a_det_done: assert property (rx_status_out == PPS_ST_RX_DET |-> $past(phy_done_out))
    else $error("detected code without done");
  a_loop_cause: assert property (rev_loopback_out |-> $past(detect_loop_in && !tx_idle_force_in, 3))
    else $error("loopback without request");
  a_pd_all: assert property ($past(block_powerdown_in, 3) |-> powered_down_out && rx_pcs_hold_out && tx_pcs_hold_out && rx_pma_hold_out)
    else $error("power-down incomplete");
  a_rx_pcs: assert property (rx_pcs_hold_out == $past(rx_pcs_reset_in || block_powerdown_in, 3))
    else $error("rx pcs hold wrong");
  a_tx_pcs: assert property (tx_pcs_hold_out == $past(tx_pcs_reset_in || block_powerdown_in, 3))
    else $error("tx pcs hold wrong");
  a_rx_pma: assert property (rx_pma_hold_out == $past(rx_pma_reset_in || block_powerdown_in, 3))
    else $error("rx pma hold wrong");
  a_idle_force: assert property (tx_elec_idle_out == $past(tx_idle_force_in || block_powerdown_in, 3))
    else $error("tx idle wrong");
endmodule
bind pps_top pps_chk u_chk (.clk_in, .reset_in, .detect_loop_in, .tx_idle_force_in,
  .block_powerdown_in, .rx_pcs_reset_in, .tx_pcs_reset_in, .rx_pma_reset_in, .rx_status_out,
  .phy_done_out, .tx_elec_idle_out, .rev_loopback_out, .rx_pcs_hold_out, .tx_pcs_hold_out,
  .rx_pma_hold_out, .powered_down_out, .rxdet_active_out);

// ### verif/pps_ctl.sv
/* link-layer controller model: power state, idle force, request, resets.
   assumes the done pulse of pps_top on phy_done_in. */
module pps_ctl
  import pps_pkg::*;
(
  input wire logic clk_in,
  input wire logic phy_done_in,
  output logic [1:0] power_sel_out,
  output logic tx_idle_force_out,
  output logic detect_loop_out,
  output logic [2:0] resets_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    power_sel_out = PPS_PWR_P1;
    tx_idle_force_out = 1'h1;
    detect_loop_out = 1'h0;
    resets_out = 3'h0;
  end
  // no limit here: a missing pulse is caught by the bench watchdog
  task automatic wait_done();
    do begin
      @(posedge clk_in);
    end while (phy_done_in !== 1'h1);
  endtask
  task automatic power(input logic [1:0] ps, input logic idle);
    @(posedge clk_in);
    power_sel_out <= ps;
    tx_idle_force_out <= idle;
    wait_done();
  endtask
  task automatic req(input logic v);
    @(posedge clk_in);
    detect_loop_out <= v;
  endtask
  task automatic detect();
    req(1'h1);
    wait_done();
    detect_loop_out <= 1'h0;
  endtask
  // two cycles is the shortest pulse the channel accepts
  task automatic pulse(input int k);
    @(posedge clk_in);
    resets_out[k] <= 1'h1;
    repeat (2) @(posedge clk_in);
    resets_out[k] <= 1'h0;
  endtask
endmodule

// ### verif/pcie_phy_status_ctrl_bench.sv
/* self-checking bench for pps_top.
   assumes pps_ctl drives power, idle, request and resets. */
module pcie_phy_status_ctrl_bench
  import pps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'h0, reset_in = 1'h1, rate_gen2_in = 1'h0, rx_far_present_in = 1'h0;
  logic rx_sig_detect_in = 1'h0, ei_inferred_in = 1'h0, rx_data_ok_in = 1'h0;
  logic block_powerdown_in = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [2:0] rx_event_in = 3'h0, rst, rx_status_out;
  logic [1:0] power_sel_in;
  logic e, pready, pslverr, phy_done_out, rx_valid_out, rx_idle_out, tx_elec_idle_out;
  logic rev_loopback_out, rxdet_active_out, rx_pcs_hold_out, tx_pcs_hold_out;
  logic rx_pma_hold_out, powered_down_out, irq_out, tx_idle_force_in, detect_loop_in;
  int mismatches = 0, compares = 0;
  pps_ctl ctl (.clk_in, .phy_done_in(phy_done_out), .power_sel_out(power_sel_in),
    .tx_idle_force_out(tx_idle_force_in), .detect_loop_out(detect_loop_in), .resets_out(rst));
  pps_top dut (.clk_in, .reset_in, .power_sel_in, .tx_idle_force_in, .detect_loop_in,
    .rate_gen2_in, .rx_far_present_in, .rx_sig_detect_in, .ei_inferred_in, .rx_data_ok_in,
    .rx_event_in, .block_powerdown_in, .rx_pcs_reset_in(rst[0]), .tx_pcs_reset_in(rst[1]),
    .rx_pma_reset_in(rst[2]), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_status_out, .phy_done_out, .rx_valid_out, .rx_idle_out, .tx_elec_idle_out,
    .rev_loopback_out, .rxdet_active_out, .rx_pcs_hold_out, .tx_pcs_hold_out,
    .rx_pma_hold_out, .powered_down_out, .irq_out);
  always #20 clk_in = ~clk_in;
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    compares++;
    if (got !== x) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, x, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'h1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic t_regs();
    apb(1'h0, PPS_OFS_CTRL, 32'h0);
    chk("ctrl", PPS_CTRL_RST, q);
    apb(1'h0, PPS_OFS_MASK, 32'h0);
    chk("mask", {29'h0, PPS_MASK_RST}, q);
    apb(1'h1, 12'h010, 32'hFFFF_FFFF);
    chk("bad addr", 32'h1, e);
  endtask
  task automatic t_dpath();
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, PPS_OFS_CTRL, {31'h0, i[1]});
      ei_inferred_in <= i[0];
      rx_sig_detect_in <= i[0];
      rx_data_ok_in <= i[0];
      settle(4);
      chk("rx_idle", i[1] ? i[0] : !i[0], rx_idle_out);
      chk("rx_valid", i[0], rx_valid_out);
    end
  endtask
  task automatic t_status();
    for (int i = 0; i < 8; i++) begin
      // a raw 011 would look like a detection result, so it is left out
      if (i != 3) begin
        @(posedge clk_in);
        rx_event_in <= i[2:0];
        settle(4);
        chk("status", i, rx_status_out);
      end
    end
    // a mask bit of one lets its status bit through
    apb(1'h1, PPS_OFS_MASK, 32'h7);
    settle(2);
    chk("irq", 32'h1, irq_out);
    apb(1'h0, PPS_OFS_IRQ, 32'h0);
    chk("irq stat", 32'h4, q);
    apb(1'h1, PPS_OFS_MASK, 32'h0);
    settle(2);
    chk("irq masked", 32'h0, irq_out);
    apb(1'h1, PPS_OFS_MASK, 32'h7);
    rx_event_in <= PPS_ST_OK;
    settle(4);
    apb(1'h1, PPS_OFS_IRQ, 32'h7);
    settle(2);
    chk("irq clear", 32'h0, irq_out);
  endtask
  task automatic t_power();
    for (int i = 0; i < 4; i++) begin
      ctl.power(i[1:0], 1'h1);
      @(negedge clk_in);
      chk("done", 32'h0, phy_done_out);
      apb(1'h0, PPS_OFS_STAT, 32'h0);
      chk("power", i, q[1:0]);
    end
    @(posedge clk_in);
    rate_gen2_in <= 1'h1;
    ctl.wait_done();
    apb(1'h0, PPS_OFS_STAT, 32'h0);
    chk("gen2", 32'h1, q[3]);
    ctl.power(PPS_PWR_P1, 1'h1);
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk_in);
      rx_far_present_in <= i[0];
      ctl.detect();
      @(negedge clk_in);
      chk("detect", i[0] ? PPS_ST_RX_DET : PPS_ST_OK, rx_status_out);
    end
    ctl.power(PPS_PWR_P0, 1'h0);
    ctl.req(1'h1);
    settle(5);
    chk("loopback", 32'h1, rev_loopback_out);
    ctl.req(1'h0);
    settle(4);
    chk("loopback off", 32'h0, rev_loopback_out);
  endtask
  task automatic t_resets();
    for (int k = 0; k < 3; k++) begin
      ctl.pulse(k);
      settle(1);
      chk("hold", 32'h1 << k, {rx_pma_hold_out, tx_pcs_hold_out, rx_pcs_hold_out});
    end
    @(posedge clk_in);
    block_powerdown_in <= 1'h1;
    settle(4);
    chk("powerdown", 32'h1F, {powered_down_out, rx_pma_hold_out, tx_pcs_hold_out,
      rx_pcs_hold_out, tx_elec_idle_out});
  endtask
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'h0;
    settle(4);
    t_regs();
    t_dpath();
    t_status();
    t_power();
    t_resets();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    give_verdict();
  end
endmodule
